/* File: scr_arbiter.sv */
// Purpose: three-requester bus arbiter, fixed or rotating priority
// Assumes: requests are synchronous levels, grant is re-decided each cycle
// Notes: boost lifts the processor above everyone while it is in an irq or fiq
module scr_arbiter
  import scr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rotate_mode,
  input wire logic cpu_boost,
  input wire logic [2:0] req,
  output logic [1:0] grant_reg
);
  logic [1:0] last_reg;
  logic [1:0] grant_next;

  // pick first requester from a starting index, wrapping at three
  function automatic logic [1:0] pick_from(input logic [2:0] r,
                                           input logic [1:0] start);
    logic [1:0] idx;
    logic [1:0] res;
    res = MST_NONE;
    idx = start;
    for (int i = 0; i < 3; i++) begin
      if (res == MST_NONE && r[idx]) begin
        res = idx;
      end
      idx = (idx == MST_CPU) ? MST_AUDIO : idx + 2'h1;
    end
    return res;
  endfunction : pick_from

  // boost first, then rotation or the fixed order
  always_comb begin
    if (cpu_boost && req[MST_CPU]) begin
      grant_next = MST_CPU;
    end else if (rotate_mode) begin
      grant_next = pick_from(req, (last_reg == MST_CPU || last_reg == MST_NONE)
                             ? MST_AUDIO : last_reg + 2'h1);
    end else begin
      grant_next = pick_from(req, MST_AUDIO);
    end
  end

  // grant and rotation pointer
  always_ff @(posedge clock) begin
    if (rst) begin
      grant_reg <= MST_NONE;
      last_reg <= MST_NONE;
    end else begin
      grant_reg <= grant_next;
      if (grant_next != MST_NONE) begin
        last_reg <= grant_next;
      end
    end
  end
endmodule : scr_arbiter

/* File: scr_ctrl.sv */
// Purpose: peripheral resets, bus arbitration control and timer pin routing
// Assumes: register port with read data one cycle after the read strobe
// Notes: routing outputs are registered, so pins follow writes by a cycle
//
// The plain strobed port was decided locally.

// Overview of operation
// - bit 16 holds audio controller in reset
// - bit 11 holds usb device in reset
// - bit 10 resets both serial masters
// - bit 9 two-wire reset, bit 8 pwm
// - bit 5 resets timer and watchdog together
// - bit 1 serial port1, bit 0 port0
// - mode bit: fixed or round-robin arbitration
// - fixed order: audio, flash master, processor
// - boost gives processor top priority in irq or fiq
// - irq status set when boost and irq or fiq
// - write one clears status, zero keeps
// - timer3 input select, codes above four disable
// - bits 28:24 enable timer3 output per pin
// - several timer outputs may drive together
// - timer2 input select, codes above four disable
// - timer1 input select, codes above four disable
// - timer0 input select, codes above four disable
module scr_ctrl
  import scr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic irq_req,
  input wire logic fiq_req,
  input wire logic [2:0] bus_req,
  output logic [1:0] bus_grant,
  output logic arbitration_mode_sel,
  output logic cpu_boost_active,
  output logic audio_ctrl_reset,
  output logic usb_device_reset,
  output logic serial_master_reset,
  output logic twi_reset,
  output logic pwm_reset,
  output logic timer_watchdog_reset,
  output logic serial_port1_reset,
  output logic serial_port0_reset,
  input wire logic [4:0] t3_pin_in,
  input wire logic [4:0] t2_pin_in,
  input wire logic [4:0] t1_pin_in,
  input wire logic [4:0] t0_pin_in,
  input wire logic [3:0] timer_out,
  output logic [3:0] timer_in,
  output logic [4:0] t3_pin_out,
  output logic [4:0] t3_pin_oe,
  output logic [4:0] t2_pin_out,
  output logic [4:0] t2_pin_oe,
  output logic [4:0] t1_pin_out,
  output logic [4:0] t1_pin_oe,
  output logic [4:0] t0_pin_out,
  output logic [4:0] t0_pin_oe
);
  logic [31:0] reset_ctrl_reg;
  logic arb_mode_reg;
  logic boost_en_reg;
  logic irq_act_reg;
  logic [31:0] route_reg;
  logic wr_reset;
  logic wr_arb;
  logic wr_route;
  logic [3:0] timer_in_next;
  logic boost_now;
  logic [31:0] arb_word;
  logic [31:0] rdata_next;

  // select one of five pins, anything above four reads as low
  function automatic logic route_in(input logic [2:0] sel,
                                    input logic [4:0] pins);
    logic res;
    res = 1'b0;
    if (sel <= SEL_MAX) begin
      res = pins[sel];
    end
    return res;
  endfunction : route_in

  // timer output copied to all five pins; the enable bits then mask it per pin
  function automatic logic [4:0] fan_out(input logic val);
    return {5{val}};
  endfunction : fan_out

  // write decode per register, unmapped offsets match nothing
  assign wr_reset = wr_en && addr == OFS_RESET_CTRL;
  assign wr_arb = wr_en && addr == OFS_BUS_ARB;
  assign wr_route = wr_en && addr == OFS_PIN_ROUTE;

  // boost request level; one term so status, arbiter and output agree
  assign boost_now = boost_en_reg && (irq_req || fiq_req);

  // peripheral reset bits hold their value until rewritten
  always_ff @(posedge clock) begin
    if (rst) begin
      reset_ctrl_reg <= RST_RESET_CTRL;
    end else if (wr_reset) begin
      reset_ctrl_reg <= wdata & RESET_CTRL_MASK;
    end
  end

  // reset lines to the peripherals, registered for clean edges
  always_ff @(posedge clock) begin
    if (rst) begin
      audio_ctrl_reset <= 1'b0;
      usb_device_reset <= 1'b0;
      serial_master_reset <= 1'b0;
      twi_reset <= 1'b0;
      pwm_reset <= 1'b0;
      timer_watchdog_reset <= 1'b0;
      serial_port1_reset <= 1'b0;
      serial_port0_reset <= 1'b0;
    end else begin
      audio_ctrl_reset <= reset_ctrl_reg[BIT_AUDIO];
      usb_device_reset <= reset_ctrl_reg[BIT_USB];
      serial_master_reset <= reset_ctrl_reg[BIT_SPIM];
      twi_reset <= reset_ctrl_reg[BIT_TWI];
      pwm_reset <= reset_ctrl_reg[BIT_PWM];
      timer_watchdog_reset <= reset_ctrl_reg[BIT_TMR];
      serial_port1_reset <= reset_ctrl_reg[BIT_UART1];
      serial_port0_reset <= reset_ctrl_reg[BIT_UART0];
    end
  end

  // arbitration control bits
  always_ff @(posedge clock) begin
    if (rst) begin
      arb_mode_reg <= RST_BUS_ARB[BIT_ARB_MODE];
      boost_en_reg <= RST_BUS_ARB[BIT_BOOST_EN];
    end else if (wr_arb) begin
      arb_mode_reg <= wdata[BIT_ARB_MODE];
      boost_en_reg <= wdata[BIT_BOOST_EN];
    end
  end

  // sticky irq status: a new event beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_act_reg <= RST_BUS_ARB[BIT_IRQ_ACT];
    end else if (boost_now) begin
      irq_act_reg <= 1'b1;
    end else if (wr_arb && wdata[BIT_IRQ_ACT]) begin
      irq_act_reg <= 1'b0;
    end
  end

  // mode and boost level to the output ports, a cycle behind what the arbiter uses
  always_ff @(posedge clock) begin
    if (rst) begin
      arbitration_mode_sel <= 1'b0;
      cpu_boost_active <= 1'b0;
    end else begin
      arbitration_mode_sel <= arb_mode_reg;
      cpu_boost_active <= boost_now;
    end
  end

  // arbiter follows the mode; boost only while an irq or fiq is pending
  scr_arbiter scr_arbiter_i (
    .clock(clock),
    .rst(rst),
    .rotate_mode(arb_mode_reg),
    .cpu_boost(boost_now),
    .req(bus_req),
    .grant_reg(bus_grant)
  );

  // pin routing register
  always_ff @(posedge clock) begin
    if (rst) begin
      route_reg <= RST_PIN_ROUTE;
    end else if (wr_route) begin
      route_reg <= wdata;
    end
  end

  // timer inputs picked from the pins per select field
  always_comb begin
    timer_in_next[3] = route_in(route_reg[POS_T3_IN +: 3],
                                t3_pin_in);
    timer_in_next[2] = route_in(route_reg[POS_T2_IN +: 3],
                                t2_pin_in);
    timer_in_next[1] = route_in(route_reg[POS_T1_IN +: 3],
                                t1_pin_in);
    timer_in_next[0] = route_in(route_reg[POS_T0_IN +: 3],
                                t0_pin_in);
  end

  // routed inputs registered; costs one cycle of pin-to-timer delay
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_in <= 4'h0;
    end else begin
      timer_in <= timer_in_next;
    end
  end

  // timer 3 pins: enables are independent, so any subset drives at once
  always_ff @(posedge clock) begin
    if (rst) begin
      t3_pin_out <= 5'h00;
      t3_pin_oe <= 5'h00;
    end else begin
      t3_pin_oe <= route_reg[POS_T3_OUT +: 5];
      t3_pin_out <= fan_out(timer_out[3]) &
                    route_reg[POS_T3_OUT +: 5];
    end
  end

  // timer 2 pins, same scheme as timer 3
  always_ff @(posedge clock) begin
    if (rst) begin
      t2_pin_out <= 5'h00;
      t2_pin_oe <= 5'h00;
    end else begin
      t2_pin_oe <= route_reg[POS_T2_OUT +: 5];
      t2_pin_out <= fan_out(timer_out[2]) & route_reg[POS_T2_OUT +: 5];
    end
  end

  // timer 1 pins, same scheme as timer 3
  always_ff @(posedge clock) begin
    if (rst) begin
      t1_pin_out <= 5'h00;
      t1_pin_oe <= 5'h00;
    end else begin
      t1_pin_oe <= route_reg[POS_T1_OUT +: 5];
      t1_pin_out <= fan_out(timer_out[1]) & route_reg[POS_T1_OUT +: 5];
    end
  end

  // timer 0 pins, same scheme as timer 3
  always_ff @(posedge clock) begin
    if (rst) begin
      t0_pin_out <= 5'h00;
      t0_pin_oe <= 5'h00;
    end else begin
      t0_pin_oe <= route_reg[POS_T0_OUT +: 5];
      t0_pin_out <= fan_out(timer_out[0]) & route_reg[POS_T0_OUT +: 5];
    end
  end

  // arbitration view: only mode, boost and status exist, rest reads zero
  always_comb begin
    arb_word = 32'h0000_0000;
    arb_word[BIT_ARB_MODE] = arb_mode_reg;
    arb_word[BIT_BOOST_EN] = boost_en_reg;
    arb_word[BIT_IRQ_ACT] = irq_act_reg;
  end

  // read mux; idle cycles and unmapped offsets give zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        OFS_RESET_CTRL: rdata_next = reset_ctrl_reg;
        OFS_BUS_ARB: rdata_next = arb_word;
        OFS_PIN_ROUTE: rdata_next = route_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rdata_next;
    end
  end
endmodule : scr_ctrl

/* File: scr_ctrl_bench.sv */
// Purpose: directed register-port checks of the control bank
// Assumes: read data one cycle after the strobe, outputs two after a write
// Notes: waits are fixed counts since every latency is fixed
module scr_ctrl_bench
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0, rd_en = 1'b0, irq_req = 1'b0, fiq_req = 1'b0;
  logic [2:0] bus_req = 3'h0;
  logic [4:0] t3_pin_in = 5'h0, t2_pin_in = 5'h0, t1_pin_in = 5'h0;
  logic [4:0] t0_pin_in = 5'h0, pins;
  logic [3:0] timer_out = 4'h0, timer_in;
  logic [31:0] rdata, pv, ein;
  logic [1:0] bus_grant, g0;
  logic arbitration_mode_sel, cpu_boost_active, audio_ctrl_reset;
  logic usb_device_reset, serial_master_reset, twi_reset, pwm_reset;
  logic timer_watchdog_reset, serial_port1_reset, serial_port0_reset;
  logic [4:0] t3_pin_out, t3_pin_oe, t2_pin_out, t2_pin_oe;
  logic [4:0] t1_pin_out, t1_pin_oe, t0_pin_out, t0_pin_oe;
  int fails = 0, checked = 0;
  int bits [8] = '{16, 11, 10, 9, 8, 5, 1, 0};
  wire logic [7:0] rsts = {audio_ctrl_reset, usb_device_reset,
    serial_master_reset, twi_reset, pwm_reset, timer_watchdog_reset,
    serial_port1_reset, serial_port0_reset};
  // timer pin buses packed timer 3 first
  wire logic [19:0] oes = {t3_pin_oe, t2_pin_oe, t1_pin_oe, t0_pin_oe};
  wire logic [19:0] outs = {t3_pin_out, t2_pin_out, t1_pin_out, t0_pin_out};
  // free-running 40 MHz clock
  always #12.5 clock = ~clock;
  scr_ctrl scr_ctrl_i (.*);
  // compare tasks count every check, unknowns never match
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 cmp(rdata, e);
  endtask : rd
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // main sequence: reset values, resets, arbitration, pin routing
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_BUS_ARB, RST_BUS_ARB);
    rd(OFS_PIN_ROUTE, RST_PIN_ROUTE);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_RESET_CTRL, 32'h1 << bits[i]);
      step(3);
      cmp({24'h0, rsts}, 32'h80 >> i);
    end
    wr(OFS_RESET_CTRL, 32'hFFFF_FFFF);
    rd(OFS_RESET_CTRL, RESET_CTRL_MASK);
    step(4);
    cmp({24'h0, rsts}, 32'hFF);
    wr(OFS_RESET_CTRL, 32'h0);
    // boost lifts the processor; status is sticky until written one
    wr(OFS_BUS_ARB, 32'h10);
    irq_req <= 1'b1;
    bus_req <= 3'h7;
    step(3);
    cmp({30'h0, bus_grant}, {30'h0, MST_CPU});
    cmp({31'h0, cpu_boost_active}, 32'h1);
    rd(OFS_BUS_ARB, 32'h30);
    wr(OFS_BUS_ARB, 32'h10);
    irq_req <= 1'b0;
    step(3);
    cmp({30'h0, bus_grant}, {30'h0, MST_AUDIO});
    cmp({31'h0, cpu_boost_active}, 32'h0);
    rd(OFS_BUS_ARB, 32'h30);
    wr(OFS_BUS_ARB, 32'h30);
    bus_req <= 3'h6;
    step(3);
    cmp({30'h0, bus_grant}, {30'h0, MST_FLASH});
    rd(OFS_BUS_ARB, 32'h10);
    wr(OFS_BUS_ARB, 32'h10);
    fiq_req <= 1'b1;
    step(3);
    cmp({30'h0, bus_grant}, {30'h0, MST_CPU});
    rd(OFS_BUS_ARB, 32'h30);
    // clear meets the last cycle of a request: the set must win
    wr(OFS_BUS_ARB, 32'h30);
    fiq_req <= 1'b0;
    rd(OFS_BUS_ARB, 32'h30);
    // rotating mode hands the bus on to the next requester
    wr(OFS_BUS_ARB, 32'h01);
    fiq_req <= 1'b0;
    bus_req <= 3'h7;
    step(3);
    cmp({31'h0, arbitration_mode_sel}, 32'h1);
    g0 = bus_grant;
    ein = (g0 == MST_CPU) ? 32'h0 : 32'(g0) + 32'h1;
    step(1);
    cmp({30'h0, bus_grant}, ein);
    // every input code on all four timers; disabled codes see all pins high
    for (int c = 0; c < 8; c++) begin
      pv = {c[2:0], 5'h15, c[2:0], 5'h0A, c[2:0], 5'h13, c[2:0], 5'h0C};
      wr(OFS_PIN_ROUTE, pv);
      pins = (c < 5) ? 5'(1 << c) : 5'h1F;
      timer_out <= 4'hA;
      t3_pin_in <= pins;
      t2_pin_in <= pins;
      t1_pin_in <= pins;
      t0_pin_in <= pins;
      step(3);
      ein = (c < 5) ? 32'h1 : 32'h0;
      cmp({31'h0, timer_in[3]}, ein);
      cmp({31'h0, timer_in[2]}, ein);
      cmp({31'h0, timer_in[1]}, ein);
      cmp({31'h0, timer_in[0]}, ein);
    end
    ein = {12'h0, pv[28:24], pv[20:16], pv[12:8], pv[4:0]};
    cmp({12'h0, oes}, ein);
    cmp({12'h0, outs}, 32'h000A_8260);
    rd(OFS_PIN_ROUTE, pv);
    end_of_test();
  end
endmodule : scr_ctrl_bench

/* File: scr_ctrl_monitor.sv */
// Purpose: port-level checks of the control bank
// Assumes: one clock, synchronous active-high reset
// Notes: a write seen at one edge reaches the outputs two edges later
module scr_ctrl_monitor
  import scr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [2:0] bus_req,
  input wire logic [1:0] bus_grant,
  input wire logic arbitration_mode_sel,
  input wire logic cpu_boost_active,
  input wire logic audio_ctrl_reset,
  input wire logic usb_device_reset,
  input wire logic serial_master_reset,
  input wire logic twi_reset,
  input wire logic pwm_reset,
  input wire logic timer_watchdog_reset,
  input wire logic serial_port1_reset,
  input wire logic serial_port0_reset,
  input wire logic [3:0] timer_in,
  input wire logic [4:0] t3_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // write strobes decoded per register
  logic wr_rst, wr_arb, wr_pin;
  assign wr_rst = wr_en && addr == OFS_RESET_CTRL;
  assign wr_arb = wr_en && addr == OFS_BUS_ARB;
  assign wr_pin = wr_en && addr == OFS_PIN_ROUTE;
  chk_audio_follow:
    assert property (wr_rst |-> ##2 audio_ctrl_reset == $past(wdata[16], 2))
      else $error("audio reset does not follow write");
  chk_periph_follow:
    assert property (wr_rst |-> ##2 {usb_device_reset, serial_master_reset,
      twi_reset, pwm_reset} == $past(wdata[11:8], 2))
      else $error("peripheral resets do not follow write");
  chk_timer_follow:
    assert property (wr_rst |-> ##2 {timer_watchdog_reset, serial_port1_reset,
      serial_port0_reset} == $past({wdata[5], wdata[1:0]}, 2))
      else $error("timer or serial resets do not follow write");
  chk_reset_hold:
    assert property (audio_ctrl_reset && !$past(wr_rst) |=> audio_ctrl_reset)
      else $error("audio reset dropped without a write");
  chk_mode_follow:
    assert property (wr_arb |-> ##2 arbitration_mode_sel == $past(wdata[0], 2))
      else $error("mode select does not follow write");
  chk_fixed_order:
    assert property (bus_req[0] && !arbitration_mode_sel && !cpu_boost_active
      ##1 !arbitration_mode_sel && !cpu_boost_active |-> bus_grant == MST_AUDIO)
      else $error("audio not granted first in fixed mode");
  chk_boost_cpu:
    assert property (bus_req[2] && cpu_boost_active ##1 cpu_boost_active
      |-> bus_grant == MST_CPU)
      else $error("boosted processor not granted");
  chk_input_off:
    assert property (wr_pin && wdata[31:29] > SEL_MAX |-> ##2 !timer_in[3])
      else $error("timer 3 input not disabled");
  chk_oe_follow:
    assert property (wr_pin |-> ##2 t3_pin_oe == $past(wdata[28:24], 2))
      else $error("timer 3 output enables do not follow write");
  chk_read_idle:
    assert property (!$past(rd_en) |-> rdata == 32'h0)
      else $error("read data outside the read slot");
endmodule : scr_ctrl_monitor

bind scr_ctrl scr_ctrl_monitor scr_ctrl_monitor_i (.*);

/* File: scr_pkg.sv */
// Purpose: constants for the system control register bank
// Assumes: plain register port, byte addresses, 32-bit data
// Notes: offsets, field positions and reset values live here only
package scr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_RESET_CTRL = 8'h14;
  localparam logic [7:0] OFS_BUS_ARB = 8'h20;
  localparam logic [7:0] OFS_PIN_ROUTE = 8'h30;
  localparam logic [31:0] RST_RESET_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_BUS_ARB = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_ROUTE = 32'h0000_0000;
  // writable bits of the peripheral reset register
  localparam logic [31:0] RESET_CTRL_MASK = 32'h0001_0F23;
  localparam int BIT_AUDIO = 16;
  localparam int BIT_USB = 11;
  localparam int BIT_SPIM = 10;
  localparam int BIT_TWI = 9;
  localparam int BIT_PWM = 8;
  localparam int BIT_TMR = 5;
  localparam int BIT_UART1 = 1;
  localparam int BIT_UART0 = 0;
  localparam int BIT_ARB_MODE = 0;
  localparam int BIT_BOOST_EN = 4;
  localparam int BIT_IRQ_ACT = 5;
  localparam int POS_T3_IN = 29;
  localparam int POS_T3_OUT = 24;
  localparam int POS_T2_IN = 21;
  localparam int POS_T2_OUT = 16;
  localparam int POS_T1_IN = 13;
  localparam int POS_T1_OUT = 8;
  localparam int POS_T0_IN = 5;
  localparam int POS_T0_OUT = 0;
  localparam logic [2:0] SEL_MAX = 3'h4;
  // arbiter requester indices, lowest wins in fixed mode
  localparam logic [1:0] MST_AUDIO = 2'h0;
  localparam logic [1:0] MST_FLASH = 2'h1;
  localparam logic [1:0] MST_CPU = 2'h2;
  localparam logic [1:0] MST_NONE = 2'h3;
endpackage : scr_pkg
